/* tmrc_defines.vh */
`ifndef TMRC_DEFINES_VH
`define TMRC_DEFINES_VH

// byte addresses of the special function registers
`define TMRC_ADDR_CTRL      8'h88
`define TMRC_ADDR_MODE      8'h89
`define TMRC_ADDR_LOW0      8'h8a
`define TMRC_ADDR_HIGH0     8'h8c

// bit addresses of the control register, bit 0 to bit 7
`define TMRC_BIT_ADDR_FIRST 8'h88
`define TMRC_BIT_ADDR_LAST  8'h8f

// control register fields
`define TMRC_CTL_OVF1       7
`define TMRC_CTL_RUN1       6
`define TMRC_CTL_OVF0       5
`define TMRC_CTL_RUN0       4
`define TMRC_CTL_REQ1       3
`define TMRC_CTL_TRIG1      2
`define TMRC_CTL_REQ0       1
`define TMRC_CTL_TRIG0      0

// mode register fields for the first timer
`define TMRC_MOD_FIRST_PIN_GATING_ENABLE      3
`define TMRC_MOD_CSEL0      2
`define TMRC_MOD_M1         1
`define TMRC_MOD_M0         0

// mode field encodings
`define TMRC_MODE_13BIT     2'b00
`define TMRC_MODE_16BIT     2'b01
`define TMRC_MODE_RELOAD    2'b10
`define TMRC_MODE_SPLIT     2'b11

// reset values
`define TMRC_RST_CTRL       8'h00
`define TMRC_RST_MODE       8'h00
`define TMRC_RST_COUNT      8'h00
`define TMRC_RST_RDATA      8'h00

`endif

/* tmrc_pin_sync.v */
`timescale 1ns/10ps
`include "tmrc_defines.vh"

module tmrc_pin_sync (
	// clock and reset
	input  wire i_mclk,
	input  wire i_rst_b,
	// raw pin
	input  wire i_pin,
	// synchronised level and falling edge
	output wire o_level,
	output wire o_fall
);

	reg meta_r;
	reg sync_r;
	reg prev_r;

	// pins idle high, so reset to one to avoid a false edge at release
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= i_pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign o_level = sync_r;
	assign o_fall  = prev_r & ~sync_r;

endmodule // tmrc_pin_sync

/* tmrc_count0.v */
`timescale 1ns/10ps
`include "tmrc_defines.vh"

module tmrc_count0 (
	// clock and reset
	input  wire       i_mclk,
	input  wire       i_rst_b,
	// mode and increments
	input  wire [1:0] i_mode,
	input  wire       i_inc_lo,
	input  wire       i_inc_hi,
	// software writes
	input  wire       i_wr_lo,
	input  wire       i_wr_hi,
	input  wire [7:0] i_wdata,
	// counter state and overflow pulses
	output reg  [7:0] o_lo,
	output reg  [7:0] o_hi,
	output reg        o_ovf_lo,
	output reg        o_ovf_hi
);

	reg [7:0] lo_nxt;
	reg [7:0] hi_nxt;

	// byte increment, wraps at all ones
	function [7:0] inc8;
		input [7:0] val;
		begin
			inc8 = val + 8'h01;
		end
	endfunction

	always @* begin
		lo_nxt   = o_lo;
		hi_nxt   = o_hi;
		o_ovf_lo = 1'b0;
		o_ovf_hi = 1'b0;
		case (i_mode)
		`TMRC_MODE_13BIT: begin
			if (i_inc_lo) begin
				// upper three low bits are left alone
				{hi_nxt, lo_nxt[4:0]} = {o_hi, o_lo[4:0]} + 13'h0001; // (R2) (R18)
				o_ovf_lo = (&o_hi) & (&o_lo[4:0]); // (R18)
			end
		end
		`TMRC_MODE_16BIT: begin
			if (i_inc_lo) begin
				{hi_nxt, lo_nxt} = {o_hi, o_lo} + 16'h0001; // (R3)
				o_ovf_lo = (&o_hi) & (&o_lo); // (R3)
			end
		end
		`TMRC_MODE_RELOAD: begin
			if (i_inc_lo) begin
				o_ovf_lo = &o_lo; // (R4)
				lo_nxt   = (&o_lo) ? o_hi : inc8(o_lo); // (R4)
			end
		end
		`TMRC_MODE_SPLIT: begin
			if (i_inc_lo) begin
				lo_nxt   = inc8(o_lo); // (R5)
				o_ovf_lo = &o_lo; // (R5)
			end
			if (i_inc_hi) begin
				hi_nxt   = inc8(o_hi); // (R5)
				o_ovf_hi = &o_hi; // (R5)
			end
		end
		default: begin
			lo_nxt = o_lo;
		end
		endcase
		// a software write wins over a count in the same cycle
		if (i_wr_lo)
			lo_nxt = i_wdata;
		if (i_wr_hi)
			hi_nxt = i_wdata;
	end

	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_lo <= `TMRC_RST_COUNT;
			o_hi <= `TMRC_RST_COUNT;
		end else begin
			o_lo <= lo_nxt;
			o_hi <= hi_nxt;
		end
	end

endmodule // tmrc_count0

/* tmrc_top.v */
// How it works
// (R1) counter-select picks count pin or clock
// (R2) mode 00: high byte with prescaler
// (R3) mode 01: 16-bit cascaded, no prescaler
// (R4) mode 10: low byte reloads from high
// (R5) mode 11: split, high byte on second run
// (R6) second overflow flag set, cleared on vector
// (R7) first overflow flag set, cleared on vector
// (R8) second run bit gates its counting
// (R9) first run bit gates its counting
// (R10) second request flag on edge or level
// (R11) first request flag on edge or level
// (R12) vector clears request only in edge mode
// (R13) second trigger bit: edge set, level clear
// (R14) first trigger bit: edge set, level clear
// (R15) low control nibble only serves pins
// (R16) control register bit addressable, resets zero
// (R17) gate bit adds first pin high condition
// (R18) mode 00 is 13-bit, overflow sets flag
// (R19) count pin synchronised, falling edge counts
// (R20) flags also writable by software; request flags in level mode follow the pin instead
`timescale 1ns/10ps
`include "tmrc_defines.vh"

module tmrc_top (
	// clock and reset
	input  wire       i_mclk,
	input  wire       i_rst_b,
	// byte access to special function registers
	input  wire [7:0] i_sfr_addr,
	input  wire       i_sfr_wr,
	input  wire       i_sfr_rd,
	input  wire [7:0] i_sfr_wdata,
	output reg  [7:0] o_sfr_rdata,
	// bit access to the control register
	input  wire [7:0] i_bit_addr,
	input  wire       i_bit_wr,
	input  wire       i_bit_rd,
	input  wire       i_bit_wdata,
	output reg        o_bit_rdata,
	// interrupt vectoring acknowledges from the core
	input  wire       i_vec_first_tmr,
	input  wire       i_vec_second_tmr,
	input  wire       i_vec_first_ext,
	input  wire       i_vec_second_ext,
	// overflow of the second timer's own datapath
	input  wire       i_second_ovf,
	// pins
	input  wire       i_first_count_input_pin,
	input  wire       i_first_ext_irq_pin,
	input  wire       i_second_ext_irq_pin,
	// state
	output reg  [7:0] o_timer_run_and_irq_control,
	output wire [7:0] o_first_counter_low_byte,
	output wire [7:0] o_first_counter_high_byte
);

	// control register, kept in the output flop itself
	reg  [7:0] timer_mode_select_reg_r;
	reg  [7:0] ctl_nxt;

	// read data next values
	reg  [7:0] rdata_nxt;
	reg        bit_rdata_nxt;

	// synchronised pins
	wire       count_pin_fall;
	wire       first_pin_level;
	wire       first_pin_fall;
	wire       second_pin_level;
	wire       second_pin_fall;

	// counter datapath
	wire       ovf_lo;
	wire       ovf_hi;
	wire       wr_lo;
	wire       wr_hi;
	wire [7:0] cnt_lo;
	wire [7:0] cnt_hi;

	// control decode
	wire       wr_ctl;
	wire       wr_mode;
	wire       bit_hit;
	wire [2:0] bit_idx;
	wire [1:0] first_mode;
	wire       count_source_select_first;
	wire       first_pin_gating_enable;
	wire       first_run_bit;
	wire       second_run_bit;
	wire       first_ext_trigger_type;
	wire       second_ext_trigger_type;

	// counting
	wire       first_tick;
	wire       first_enable;
	wire       inc_lo;
	wire       inc_hi;

	// overflow sources
	wire       set_first_ovf;
	wire       set_second_ovf;

	// byte read mux, shared by the read path
	function [7:0] rd_mux;
		input [7:0] addr;
		input [7:0] ctl;
		input [7:0] mode;
		input [7:0] lo;
		input [7:0] hi;
		begin
			case (addr)
			`TMRC_ADDR_CTRL:  rd_mux = ctl;
			`TMRC_ADDR_MODE:  rd_mux = mode;
			`TMRC_ADDR_LOW0:  rd_mux = lo;
			`TMRC_ADDR_HIGH0: rd_mux = hi;
			default:          rd_mux = `TMRC_RST_RDATA;
			endcase
		end
	endfunction

	// new value of a request flag
	function req_next;
		input cur;
		input edge_mode;
		input fall;
		input level;
		input vec;
		begin
			if (edge_mode)
				// hardware set wins over the vector clear
				req_next = fall | (cur & ~vec); // (R12)
			else
				// level mode: flag follows the low pin
				req_next = ~level; // (R12)
		end
	endfunction

	// write strobe for one byte register
	function sfr_hit;
		input       strobe;
		input [7:0] addr;
		input [7:0] target;
		begin
			sfr_hit = strobe & (addr == target);
		end
	endfunction

	// overflow flag: hardware set wins over the vector clear
	function ovf_next;
		input cur;
		input vec;
		input set;
		begin
			ovf_next = set | (cur & ~vec);
		end
	endfunction

	// pin synchronisers
	tmrc_pin_sync u_sync_count (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_pin   (i_first_count_input_pin),
		.o_level (),
		.o_fall  (count_pin_fall)
	); // (R19)

	tmrc_pin_sync u_sync_first (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_pin   (i_first_ext_irq_pin),
		.o_level (first_pin_level),
		.o_fall  (first_pin_fall)
	);

	tmrc_pin_sync u_sync_second (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_pin   (i_second_ext_irq_pin),
		.o_level (second_pin_level),
		.o_fall  (second_pin_fall)
	);

	// register decode
	assign wr_ctl  = sfr_hit(i_sfr_wr, i_sfr_addr, `TMRC_ADDR_CTRL);
	assign wr_mode = sfr_hit(i_sfr_wr, i_sfr_addr, `TMRC_ADDR_MODE);
	assign wr_lo   = sfr_hit(i_sfr_wr, i_sfr_addr, `TMRC_ADDR_LOW0);
	assign wr_hi   = sfr_hit(i_sfr_wr, i_sfr_addr, `TMRC_ADDR_HIGH0);
	assign bit_hit = (i_bit_addr >= `TMRC_BIT_ADDR_FIRST) &
	                 (i_bit_addr <= `TMRC_BIT_ADDR_LAST); // (R16)
	assign bit_idx = i_bit_addr[2:0]; // (R16)

	// fields
	assign first_mode = {timer_mode_select_reg_r[`TMRC_MOD_M1],
	                     timer_mode_select_reg_r[`TMRC_MOD_M0]};
	assign count_source_select_first = timer_mode_select_reg_r[`TMRC_MOD_CSEL0];
	assign first_pin_gating_enable   = timer_mode_select_reg_r[`TMRC_MOD_FIRST_PIN_GATING_ENABLE];
	assign first_run_bit   = o_timer_run_and_irq_control[`TMRC_CTL_RUN0];
	assign second_run_bit  = o_timer_run_and_irq_control[`TMRC_CTL_RUN1];
	assign first_ext_trigger_type  = o_timer_run_and_irq_control[`TMRC_CTL_TRIG0];
	assign second_ext_trigger_type = o_timer_run_and_irq_control[`TMRC_CTL_TRIG1];

	// count source: one tick per clock, or per pin falling edge
	assign first_tick = count_source_select_first ? count_pin_fall : 1'b1; // (R1) (R19)

	// low control nibble has no part here, only run and gate
	assign first_enable = first_run_bit &
	                      (~first_pin_gating_enable | first_pin_level); // (R9) (R17) (R15)

	assign inc_lo = first_enable & first_tick; // (R9)

	// split mode: high byte is a timer only, on the second run bit
	assign inc_hi = (first_mode == `TMRC_MODE_SPLIT) & second_run_bit; // (R5) (R8)

	tmrc_count0 u_count0 (
		.i_mclk   (i_mclk),
		.i_rst_b  (i_rst_b),
		.i_mode   (first_mode),
		.i_inc_lo (inc_lo),
		.i_inc_hi (inc_hi),
		.i_wr_lo  (wr_lo),
		.i_wr_hi  (wr_hi),
		.i_wdata  (i_sfr_wdata),
		.o_lo     (cnt_lo),
		.o_hi     (cnt_hi),
		.o_ovf_lo (ovf_lo),
		.o_ovf_hi (ovf_hi)
	);

	assign o_first_counter_low_byte  = cnt_lo;
	assign o_first_counter_high_byte = cnt_hi;

	assign set_first_ovf = ovf_lo; // (R7) (R18)
	// in split mode the high byte borrows the second overflow flag;
	// the second datapath then counts nothing on its own side
	assign set_second_ovf = ovf_hi | i_second_ovf; // (R6) (R5)

	// control register next value
	always @* begin
		ctl_nxt = o_timer_run_and_irq_control;
		// software access first so hardware events can override it
		if (wr_ctl)
			ctl_nxt = i_sfr_wdata; // (R20) (R8) (R9)
		if (i_bit_wr & bit_hit)
			ctl_nxt[bit_idx] = i_bit_wdata; // (R16) (R20)

		// overflow flags: vector clears, hardware set wins
		ctl_nxt[`TMRC_CTL_OVF1] = ovf_next(ctl_nxt[`TMRC_CTL_OVF1],
		                                   i_vec_second_tmr,
		                                   set_second_ovf); // (R6)
		ctl_nxt[`TMRC_CTL_OVF0] = ovf_next(ctl_nxt[`TMRC_CTL_OVF0],
		                                   i_vec_first_tmr,
		                                   set_first_ovf); // (R7)

		// request flags; trigger type taken from the current register
		if (second_ext_trigger_type | ~second_pin_level)
			ctl_nxt[`TMRC_CTL_REQ1] = req_next(ctl_nxt[`TMRC_CTL_REQ1],
			                                   second_ext_trigger_type,
			                                   second_pin_fall,
			                                   second_pin_level,
			                                   i_vec_second_ext); // (R10) (R13)
		else
			ctl_nxt[`TMRC_CTL_REQ1] = 1'b0; // (R12)
		if (first_ext_trigger_type | ~first_pin_level)
			ctl_nxt[`TMRC_CTL_REQ0] = req_next(ctl_nxt[`TMRC_CTL_REQ0],
			                                   first_ext_trigger_type,
			                                   first_pin_fall,
			                                   first_pin_level,
			                                   i_vec_first_ext); // (R11) (R14)
		else
			ctl_nxt[`TMRC_CTL_REQ0] = 1'b0; // (R12)
	end

	// control register, all bits zero after reset
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_timer_run_and_irq_control <= `TMRC_RST_CTRL; // (R16)
		else
			o_timer_run_and_irq_control <= ctl_nxt;
	end

	// mode register; upper nibble only stored for the second timer
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b)
			timer_mode_select_reg_r <= `TMRC_RST_MODE;
		else if (wr_mode)
			timer_mode_select_reg_r <= i_sfr_wdata;
	end

	// read data hold until the next strobe of their own kind
	always @* begin
		rdata_nxt     = o_sfr_rdata;
		bit_rdata_nxt = o_bit_rdata;
		if (i_sfr_rd)
			rdata_nxt = rd_mux(i_sfr_addr, o_timer_run_and_irq_control,
			                   timer_mode_select_reg_r, cnt_lo, cnt_hi);
		if (i_bit_rd)
			bit_rdata_nxt = bit_hit & o_timer_run_and_irq_control[bit_idx]; // (R16)
	end

	// registered read data, answer one edge after the strobe
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sfr_rdata <= `TMRC_RST_RDATA;
			o_bit_rdata <= 1'b0;
		end else begin
			o_sfr_rdata <= rdata_nxt;
			o_bit_rdata <= bit_rdata_nxt;
		end
	end

endmodule // tmrc_top

/* tmrc_top_assertions.sv */
`timescale 1ns/10ps
module tmrc_chk (
	// clock and reset
	input wire       i_mclk,
	input wire       i_rst_b,
	// register access
	input wire [7:0] i_sfr_addr,
	input wire       i_sfr_wr,
	input wire       i_sfr_rd,
	input wire [7:0] o_sfr_rdata,
	input wire [7:0] i_bit_addr,
	input wire       i_bit_wr,
	input wire       i_bit_wdata,
	// events and pins
	input wire       i_vec_first_tmr,
	input wire       i_vec_second_tmr,
	input wire       i_vec_second_ext,
	input wire       i_second_ovf,
	input wire       i_first_ext_irq_pin,
	input wire       i_second_ext_irq_pin,
	// state
	input wire [7:0] o_timer_run_and_irq_control,
	input wire [7:0] o_first_counter_low_byte
);
	wire [7:0] c = o_timer_run_and_irq_control;
	wire       wr_any = i_sfr_wr | i_bit_wr;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// four samples so the pin synchroniser has settled
	sequence s_lvl_low;
		(!i_first_ext_irq_pin && !c[0])[*4];
	endsequence
	sequence s_edge_idle;
		(i_second_ext_irq_pin && c[2])[*4];
	endsequence
	property p_rst;
		$rose(i_rst_b) |-> c == 8'h00;
	endproperty
	property p_unmapped;
		i_sfr_rd && i_sfr_addr == 8'h8b |=> o_sfr_rdata == 8'h00;
	endproperty
	property p_bitwr;
		i_bit_wr && i_bit_addr == 8'h8c |=> c[4] == $past(i_bit_wdata);
	endproperty
	property p_ovf1;
		i_second_ovf |=> c[7];
	endproperty
	// a stopped timer cannot raise a late overflow against the clear
	property p_vec0;
		i_vec_first_tmr && !c[4] && !$past(c[4]) && !wr_any |=> !c[5];
	endproperty
	property p_vec1;
		i_vec_second_tmr && !c[6] && !$past(c[6]) && !i_second_ovf && !wr_any |=> !c[7];
	endproperty
	property p_lvl;
		s_lvl_low |=> c[1];
	endproperty
	property p_edgeclr;
		s_edge_idle ##0 (i_vec_second_ext && !wr_any) |=> !c[3];
	endproperty
	property p_stop;
		!c[4] && !$past(c[4]) && !i_sfr_wr |=> $stable(o_first_counter_low_byte);
	endproperty
	a_rst: assert property (p_rst) else $error("control not zero after reset");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_bitwr: assert property (p_bitwr) else $error("bit write lost");
	a_ovf1: assert property (p_ovf1) else $error("second overflow flag not set");
	a_vec0: assert property (p_vec0) else $error("first overflow flag not cleared");
	a_vec1: assert property (p_vec1) else $error("second overflow flag not cleared");
	a_lvl: assert property (p_lvl) else $error("level request missing");
	a_edgeclr: assert property (p_edgeclr) else $error("edge request not cleared");
	a_stop: assert property (p_stop) else $error("stopped timer moved");
endmodule // tmrc_chk

bind tmrc_top tmrc_chk tmrc_chk_i (.i_mclk, .i_rst_b, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
	.o_sfr_rdata, .i_bit_addr, .i_bit_wr, .i_bit_wdata, .i_vec_first_tmr, .i_vec_second_tmr,
	.i_vec_second_ext, .i_second_ovf, .i_first_ext_irq_pin, .i_second_ext_irq_pin,
	.o_timer_run_and_irq_control, .o_first_counter_low_byte);

/* tmrc_core_model.sv */
`timescale 1ns/10ps
module tmrc_core_model (
	// clock
	input  wire       i_mclk,
	// byte and bit access
	output reg  [7:0] o_addr,
	output reg        o_wr,
	output reg        o_rd,
	output reg  [7:0] o_wdata,
	output reg        o_bwr,
	output reg        o_brd,
	output reg        o_bdata,
	// vector acknowledges
	output reg  [3:0] o_vec,
	// answers
	input  wire [7:0] i_rdata,
	input  wire       i_bdata
);
	initial begin
		{o_addr, o_wr, o_rd, o_wdata, o_bwr, o_brd, o_bdata, o_vec} = 25'h0;
	end
	// k: 0 byte wr, 1 byte rd, 2 bit wr, 3 bit rd, 4 vector
	task acc(input [2:0] k, input [7:0] a, input [7:0] d, output [7:0] q);
		@(negedge i_mclk);
		o_addr = a;
		o_wdata = d;
		o_bdata = d[0];
		o_vec = (k == 3'd4) ? d[3:0] : 4'h0;
		{o_brd, o_bwr, o_rd, o_wr} = (k < 3'd4) ? 4'h1 << k : 4'h0;
		@(negedge i_mclk);
		{o_brd, o_bwr, o_rd, o_wr, o_vec} = 8'h00;
		// released data lines must not look valid
		o_wdata = ~d;
		o_bdata = ~d[0];
		@(negedge i_mclk);
		q = (k == 3'd3) ? {7'h00, i_bdata} : i_rdata;
	endtask
endmodule // tmrc_core_model

/* tmrc_top_tb.sv */
`timescale 1ns/10ps
module tmrc_top_tb;
	localparam WRB = 0, RDB = 1, WRT = 2, RDT = 3, VEC = 4;
	reg        clk = 1'b0;
	reg        rst_b = 1'b0;
	reg        cpin = 1'b1;
	reg        epin0 = 1'b1;
	reg        epin1 = 1'b1;
	reg        sovf = 1'b0;
	wire [7:0] addr, wdata, rdata, ctl, lo, hi;
	wire       wr, rd, bwr, brd, bdata, brdata;
	wire [3:0] vec;
	integer    err_count = 0;
	integer    check_count = 0;
	integer    i;
	reg  [7:0] d;

	tmrc_top tmrc_top_i (.i_mclk(clk), .i_rst_b(rst_b), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_bit_addr(addr),
		.i_bit_wr(bwr), .i_bit_rd(brd), .i_bit_wdata(bdata), .o_bit_rdata(brdata),
		.i_vec_first_tmr(vec[0]), .i_vec_second_tmr(vec[1]), .i_vec_first_ext(vec[2]),
		.i_vec_second_ext(vec[3]), .i_second_ovf(sovf), .i_first_count_input_pin(cpin),
		.i_first_ext_irq_pin(epin0), .i_second_ext_irq_pin(epin1),
		.o_timer_run_and_irq_control(ctl), .o_first_counter_low_byte(lo),
		.o_first_counter_high_byte(hi));
	tmrc_core_model tmrc_core_model_i (.i_mclk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
		.o_wdata(wdata), .o_bwr(bwr), .o_brd(brd), .o_bdata(bdata), .o_vec(vec),
		.i_rdata(rdata), .i_bdata(brdata));

	always #4 clk = ~clk;

	task finish_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string n, input [7:0] e, input [7:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("CHECK FAILED %0s expected %h seen %h", n, e, g);
		end
	endtask
	task acc(input [2:0] k, input [7:0] a, input [7:0] v);
		tmrc_core_model_i.acc(k, a, v, d);
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task setup(input [7:0] m, input [7:0] l, input [7:0] h);
		acc(WRB, 8'h89, m);
		acc(WRB, 8'h8a, l);
		acc(WRB, 8'h8c, h);
	endtask
	// run until the flag rises, stop, clear it by a vector
	task run_to(input [7:0] ra, input integer f);
		integer n;
		n = 0;
		acc(WRT, ra, 8'h01);
		while (ctl[f] !== 1'b1 && n < 600) begin
			cyc(1);
			n = n + 1;
		end
		acc(WRT, ra, 8'h00);
		chk("flag", 8'h01, {7'h00, ctl[f]});
		acc(VEC, 8'h00, (f == 7) ? 8'h02 : 8'h01);
		chk("flag clr", 8'h00, {7'h00, ctl[f]});
	endtask
	task t_start;
		chk("ctl rst", 8'h00, ctl);
		acc(RDB, 8'h8b, 8'h00);
		chk("unmapped", 8'h00, d);
	endtask
	task t_bits;
		for (i = 0; i < 8; i = i + 1) begin
			acc(WRT, 8'h88 + i[7:0], 8'h01);
			chk("bit set", 8'hff >> (7 - i), ctl);
		end
		acc(RDT, 8'h8d, 8'h00);
		chk("bit rd", 8'h01, d);
		for (i = 7; i >= 0; i = i - 1) begin
			acc(WRT, 8'h88 + i[7:0], 8'h00);
			chk("bit clr", 8'hff >> (8 - i), ctl);
		end
		acc(WRT, 8'h90, 8'h01);
		chk("bit out", 8'h00, ctl);
	endtask
	task t_modes;
		setup(8'h01, 8'hfe, 8'hff);
		run_to(8'h8c, 5);
		acc(RDB, 8'h8c, 8'h00);
		chk("m16 hi", 8'h00, d);
		chk("m16 lo", 8'h01, {7'h00, lo < 8'h04});
		setup(8'h00, 8'hbe, 8'hff);
		run_to(8'h8c, 5);
		chk("m13 hi", 8'h00, hi);
		chk("m13 top", 8'ha0, lo & 8'he0);
		setup(8'h02, 8'hfe, 8'h80);
		run_to(8'h8c, 5);
		chk("rld hi", 8'h80, hi);
		chk("rld lo", 8'h01, {7'h00, lo >= 8'h80 && lo < 8'h84});
	endtask
	task t_split;
		setup(8'h03, 8'h10, 8'hfe);
		run_to(8'h8e, 7);
		chk("split lo", 8'h10, lo);
		chk("split ovf0", 8'h00, ctl & 8'h20);
		sovf = 1'b1;
		cyc(1);
		sovf = 1'b0;
		chk("ovf1", 8'h80, ctl & 8'h80);
		acc(WRT, 8'h8f, 8'h00);
		chk("ovf1 sw", 8'h00, ctl & 8'h80);
	endtask
	task t_gate;
		epin0 = 1'b0;
		setup(8'h09, 8'h00, 8'h00);
		acc(WRT, 8'h8c, 8'h01);
		cyc(20);
		chk("gated", 8'h00, lo);
		epin0 = 1'b1;
		cyc(10);
		chk("ungated", 8'h01, {7'h00, lo > 8'h04});
		acc(WRT, 8'h8c, 8'h00);
	endtask
	task t_count;
		setup(8'h05, 8'h00, 8'h00);
		acc(WRT, 8'h8c, 8'h01);
		for (i = 0; i < 3; i = i + 1) begin
			cpin = 1'b0;
			cyc(4);
			cpin = 1'b1;
			cyc(4);
		end
		cyc(6);
		chk("edges", 8'h03, lo);
		acc(WRT, 8'h8c, 8'h00);
	endtask
	task t_ext;
		acc(WRT, 8'h8a, 8'h01);
		epin1 = 1'b0;
		cyc(2);
		epin1 = 1'b1;
		cyc(6);
		chk("edge req", 8'h08, ctl & 8'h08);
		acc(VEC, 8'h00, 8'h08);
		chk("edge clr", 8'h00, ctl & 8'h08);
		epin0 = 1'b0;
		cyc(6);
		acc(VEC, 8'h00, 8'h04);
		chk("level req", 8'h02, ctl & 8'h02);
		epin0 = 1'b1;
		cyc(5);
		chk("level gone", 8'h00, ctl & 8'h02);
		acc(WRT, 8'h88, 8'h01);
		epin0 = 1'b0;
		cyc(2);
		epin0 = 1'b1;
		cyc(6);
		chk("edge req0", 8'h02, ctl & 8'h02);
		acc(VEC, 8'h00, 8'h04);
		chk("edge clr0", 8'h00, ctl & 8'h02);
	endtask
	task t_reset;
		setup(8'h01, 8'h5a, 8'ha5);
		acc(WRB, 8'h88, 8'h55);
		rst_b = 1'b0;
		cyc(2);
		rst_b = 1'b1;
		chk("mid rst ctl", 8'h00, ctl);
		chk("mid rst lo", 8'h00, lo);
		chk("mid rst hi", 8'h00, hi);
		acc(RDB, 8'h89, 8'h00);
		chk("mid rst mode", 8'h00, d);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_count = err_count + 1;
		finish_test;
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		t_start;
		t_bits;
		t_modes;
		t_split;
		t_gate;
		t_count;
		t_ext;
		t_reset;
		finish_test;
	end
endmodule // tmrc_top_tb
